// ==== rtl/mpwm_pkg.sv ====
// Summary of operation
// - Each oscillator cycle start sets both the upper and the lower latch, except a latch whose comparator is high.
// - A high PWM comparator result resets the upper latch and ends bottom conduction.
// - Pulse width gating acts only on the bottom drives; top drives follow commutation.
// - A current sense result above threshold resets the lower latch and ends conduction.
// - After an overcurrent turn-off the switch stays off until the next cycle start.
// - At most one conduction pulse occurs in any oscillator cycle.
// - Current sense high with valid sensors, brake low and enable high turns bottoms off, fault low.
// - Any undervoltage flag asserts fault, turns tops off and holds bottoms low.
// - Fault is low on invalid code, enable low, overcurrent outside braking, undervoltage or overheat.
// - Thermal shutdown acts exactly like the output enable held low.
// - Fault and the three top drives are active low.
// - An invalid sensor code with brake low turns all drives off and pulls fault low.
// - Valid sensors, brake low and enable low turn all drives off, fault low.
package mpwm_pkg;
	// APB register byte addresses
	localparam logic [7:0] ctrl_addr      = 8'h00;
	localparam logic [7:0] status_addr    = 8'h04;
	localparam logic [7:0] count_addr     = 8'h08;
	// Control register fields
	localparam int         ctrl_enable_bit = 0;
	localparam int         ctrl_brake_bit  = 1;
	localparam logic [1:0] ctrl_reset      = 2'h1;
	// Status register field positions
	localparam int         st_upper_bit   = 0;
	localparam int         st_lower_bit   = 1;
	localparam int         st_valid_bit   = 2;
	localparam int         st_uv_bit      = 3;
	localparam int         st_therm_bit   = 4;
	localparam int         st_ocur_bit    = 5;
	localparam int         st_fault_bit   = 6;
	localparam int         st_step_lsb    = 8;
	// Sensor decode: invalid step marker and last step index
	localparam logic [2:0] step_invalid   = 3'h7;
	localparam logic [2:0] step_last      = 3'h5;
	// Phase indices for the six-step table
	localparam logic [1:0] ph_a           = 2'h0;
	localparam logic [1:0] ph_b           = 2'h1;
	localparam logic [1:0] ph_c           = 2'h2;
	localparam logic [2:0] drv_off        = 3'h0;
	localparam logic [2:0] drv_all        = 3'h7;
	localparam logic [15:0] cnt_reset     = 16'h0000;
	localparam logic [31:0] rd_zero       = 32'h0000_0000;
endpackage : mpwm_pkg

// ==== rtl/mpwm_top.sv ====
`timescale 1ns/1ps
// Dual-latch PWM and protection logic for a three-phase bridge controller
module mpwm_top (
	input  wire logic        mclk,
	input  wire logic        reset_n,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Motor control inputs
	input  wire logic        osc_start,
	input  wire logic        pwm_cmp,
	input  wire logic        cur_sense,
	input  wire logic        uv_logic_supply,
	input  wire logic        uv_bottom_drive_supply,
	input  wire logic        uv_reference,
	input  wire logic        thermal_shutdown,
	input  wire logic        out_enable,
	input  wire logic        brake,
	input  wire logic        sel_60deg,
	input  wire logic        fwd_rev,
	input  wire logic [2:0]  sensor,
	// Drive outputs
	output logic [2:0]       top_drive_n,
	output logic [2:0]       bottom_drive,
	output logic             fault_n
);

	// Map a sensor code to a six-step position, or the invalid marker
	function automatic logic [2:0] mpwm_step(input logic [2:0] code, input logic sel60);
		logic [2:0] s;
		s = mpwm_pkg::step_invalid;
		if (sel60) begin
			case (code)
				3'h4: s = 3'h0;
				3'h6: s = 3'h1;
				3'h7: s = 3'h2;
				3'h3: s = 3'h3;
				3'h1: s = 3'h4;
				3'h0: s = 3'h5;
				default: s = mpwm_pkg::step_invalid;
			endcase
		end else begin
			case (code)
				3'h4: s = 3'h0;
				3'h6: s = 3'h1;
				3'h2: s = 3'h2;
				3'h3: s = 3'h3;
				3'h1: s = 3'h4;
				3'h5: s = 3'h5;
				default: s = mpwm_pkg::step_invalid;
			endcase
		end
		return s;
	endfunction : mpwm_step

	// One-hot mask for a phase index
	function automatic logic [2:0] mpwm_onehot(input logic [1:0] ph);
		logic [2:0] m;
		m = mpwm_pkg::drv_off;
		m[ph] = 1'b1;
		return m;
	endfunction : mpwm_onehot

	// Reset release through two flip-flops
	// Entry into reset is immediate; only the exit is timed to the clock
	logic rst_meta;
	logic rst_sync;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	// Registered comparator and flag inputs
	// One stage only: inputs arrive synchronous, and every extra stage delays protection
	logic       osc_q;
	logic       osc_prev;
	logic       pwm_q;
	logic       cs_q;
	logic       uv_q;
	logic       therm_q;
	logic       en_q;
	logic       brake_q;
	logic       sel60_q;
	logic       fr_q;
	logic [2:0] sensor_q;
	always_ff @(posedge mclk or negedge rst_sync) begin
		if (!rst_sync) begin
			osc_q    <= 1'b0;
			osc_prev <= 1'b0;
			pwm_q    <= 1'b0;
			cs_q     <= 1'b0;
			uv_q     <= 1'b1;
			therm_q  <= 1'b0;
			en_q     <= 1'b0;
			brake_q  <= 1'b0;
			sel60_q  <= 1'b0;
			fr_q     <= 1'b0;
			sensor_q <= mpwm_pkg::drv_off;
		end else begin
			osc_q    <= osc_start;
			osc_prev <= osc_q;
			pwm_q    <= pwm_cmp;
			cs_q     <= cur_sense;
			uv_q     <= uv_logic_supply | uv_bottom_drive_supply | uv_reference;
			therm_q  <= thermal_shutdown;
			en_q     <= out_enable;
			brake_q  <= brake;
			sel60_q  <= sel_60deg;
			fr_q     <= fwd_rev;
			sensor_q <= sensor;
		end
	end

	// Cycle start is the rising edge, so a long discharge still sets the latches once
	// A second set needs osc_start to drop for at least one cycle first
	logic cycle_start;
	assign cycle_start = osc_q & ~osc_prev;

	// Software control register
	logic [1:0] ctrl;

	// Upper (PWM) and lower (current sense) latches; reset has priority over set
	// A comparator still high at cycle start therefore keeps that cycle dark
	logic upper_latch;
	logic lower_latch;
	always_ff @(posedge mclk or negedge rst_sync) begin
		if (!rst_sync) begin
			upper_latch <= 1'b0;
		end else if (pwm_q) begin
			upper_latch <= 1'b0;
		end else if (cycle_start) begin
			upper_latch <= 1'b1;
		end
	end

	// Once cleared by overcurrent the lower latch waits for the next cycle start
	always_ff @(posedge mclk or negedge rst_sync) begin
		if (!rst_sync) begin
			lower_latch <= 1'b0;
		end else if (cs_q) begin
			lower_latch <= 1'b0;
		end else if (cycle_start) begin
			lower_latch <= 1'b1;
		end
	end

	// Commutation decode: step to top and bottom phase
	// Invalid codes fall to default; the lockout logic keeps them off the pins
	logic [2:0] step;
	logic       sensor_valid;
	logic [1:0] top_ph;
	logic [1:0] bot_ph;
	always_comb begin
		step = mpwm_step(sensor_q, sel60_q);
		sensor_valid = (step != mpwm_pkg::step_invalid);
		case (step)
			3'h0: begin
				top_ph = mpwm_pkg::ph_a;
				bot_ph = mpwm_pkg::ph_c;
			end
			3'h1: begin
				top_ph = mpwm_pkg::ph_b;
				bot_ph = mpwm_pkg::ph_c;
			end
			3'h2: begin
				top_ph = mpwm_pkg::ph_b;
				bot_ph = mpwm_pkg::ph_a;
			end
			3'h3: begin
				top_ph = mpwm_pkg::ph_c;
				bot_ph = mpwm_pkg::ph_a;
			end
			3'h4: begin
				top_ph = mpwm_pkg::ph_c;
				bot_ph = mpwm_pkg::ph_b;
			end
			default: begin
				top_ph = mpwm_pkg::ph_a;
				bot_ph = mpwm_pkg::ph_b;
			end
		endcase
	end

	// Lockout conditions; thermal shutdown folds into the enable path
	logic enable_eff;
	logic brake_eff;
	logic fault_now;
	logic [2:0] com_top;
	logic [2:0] com_bot;
	logic [2:0] next_top;
	logic [2:0] next_bot;
	always_comb begin
		enable_eff = en_q & ~therm_q & ctrl[mpwm_pkg::ctrl_enable_bit];
		brake_eff  = brake_q | ctrl[mpwm_pkg::ctrl_brake_bit];
		// Reverse direction swaps the roles of the two conducting phases
		com_top = fr_q ? mpwm_onehot(top_ph) : mpwm_onehot(bot_ph);
		com_bot = fr_q ? mpwm_onehot(bot_ph) : mpwm_onehot(top_ph);
		// Fault gathers every reason that holds the bridge off
		fault_now = ~sensor_valid | ~enable_eff | cs_q | uv_q;
		// Braking drives current through the bottoms on purpose, so sensing it is no fault
		if (brake_eff) begin
			fault_now = ~sensor_valid | ~enable_eff | uv_q;
		end
		// Undervoltage outranks brake: a weak gate supply must not close any switch
		if (uv_q) begin
			next_top = mpwm_pkg::drv_off;
			next_bot = mpwm_pkg::drv_off;
		end else if (brake_eff) begin
			// Braking shorts the windings through the bottom switches
			next_top = mpwm_pkg::drv_off;
			next_bot = mpwm_pkg::drv_all;
		end else if (!sensor_valid || !enable_eff) begin
			// No trusted position or no permission to run: every switch open
			next_top = mpwm_pkg::drv_off;
			next_bot = mpwm_pkg::drv_off;
		end else begin
			// Tops follow commutation only; pulse gating goes to the bottoms
			next_top = com_top;
			if (cs_q) begin
				// Cut at once, on the same edge that clears the lower latch
				next_bot = mpwm_pkg::drv_off;
			end else if (upper_latch && lower_latch) begin
				// Both latches set: this cycle's single pulse is on
				next_bot = com_bot;
			end else begin
				// Pulse already ended by either comparator
				next_bot = mpwm_pkg::drv_off;
			end
		end
	end

	// Registered drive outputs, top drives and fault inverted for active low
	// Reset parks every switch open with fault asserted until the first decode
	always_ff @(posedge mclk or negedge rst_sync) begin
		if (!rst_sync) begin
			top_drive_n  <= mpwm_pkg::drv_all;
			bottom_drive <= mpwm_pkg::drv_off;
			fault_n      <= 1'b0;
		end else begin
			top_drive_n  <= ~next_top;
			bottom_drive <= next_bot;
			fault_n      <= ~fault_now;
		end
	end

	// Overcurrent counter: counts each rising edge of the registered current sense, braking or not
	logic [15:0] ocur_count;
	logic        cs_prev;
	always_ff @(posedge mclk or negedge rst_sync) begin
		if (!rst_sync) begin
			cs_prev    <= 1'b0;
			ocur_count <= mpwm_pkg::cnt_reset;
		end else begin
			cs_prev <= cs_q;
			// Each new overcurrent counts once; the count sticks at full scale
			if (cs_q && !cs_prev && ocur_count != 16'hffff) begin
				ocur_count <= ocur_count + 16'h0001;
			end
		end
	end

	// APB access decode
	// Access includes pready, so a write lands exactly once per transfer
	logic setup_ph;
	logic access_ph;
	logic wr_hit;
	assign setup_ph  = psel & ~penable;
	assign access_ph = psel & penable & pready;
	assign wr_hit    = access_ph & pwrite;

	// Status word shows latch state, protection causes and decoded step
	// Fault bit reads the registered pin, so software sees what the bridge sees
	logic [31:0] status_word;
	always_comb begin
		status_word = mpwm_pkg::rd_zero;
		status_word[mpwm_pkg::st_upper_bit] = upper_latch;
		status_word[mpwm_pkg::st_lower_bit] = lower_latch;
		status_word[mpwm_pkg::st_valid_bit] = sensor_valid;
		status_word[mpwm_pkg::st_uv_bit]    = uv_q;
		status_word[mpwm_pkg::st_therm_bit] = therm_q;
		status_word[mpwm_pkg::st_ocur_bit]  = cs_q;
		status_word[mpwm_pkg::st_fault_bit] = ~fault_n;
		status_word[mpwm_pkg::st_step_lsb +: 3] = step;
	end

	// Control register write, taken in the access phase
	always_ff @(posedge mclk or negedge rst_sync) begin
		if (!rst_sync) begin
			ctrl <= mpwm_pkg::ctrl_reset;
		end else if (wr_hit && paddr == mpwm_pkg::ctrl_addr) begin
			ctrl <= pwdata[1:0];
		end
	end

	// Answer one cycle after setup; read data is captured in the setup cycle
	always_ff @(posedge mclk or negedge rst_sync) begin
		if (!rst_sync) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= mpwm_pkg::rd_zero;
		end else if (setup_ph) begin
			pready  <= 1'b1;
			pslverr <= 1'b0;
			prdata  <= mpwm_pkg::rd_zero;
			// Only the control register takes writes; the other two are read-only
			if (paddr == mpwm_pkg::ctrl_addr) begin
				prdata[1:0] <= ctrl;
			end else if (paddr == mpwm_pkg::status_addr) begin
				if (!pwrite) begin
					prdata <= status_word;
				end else begin
					pslverr <= 1'b1; // Read-only register
				end
			end else if (paddr == mpwm_pkg::count_addr) begin
				if (!pwrite) begin
					prdata[15:0] <= ocur_count;
				end else begin
					pslverr <= 1'b1;
				end
			end else begin
				pslverr <= 1'b1; // Unmapped address
			end
		end else begin
			// Idle or access cycle: the answer stands for one cycle only
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= mpwm_pkg::rd_zero;
		end
	end

endmodule : mpwm_top

// ==== verification/mpwm_properties.sv ====
`timescale 1ns/1ps
// Port checks on the drive, fault and bus paths; flags reach the drives two edges later, pwm_cmp and osc_start three
module mpwm_checker (
	input wire logic       mclk,
	input wire logic       reset_n,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	input wire logic       osc_start,
	input wire logic       pwm_cmp,
	input wire logic       cur_sense,
	input wire logic       uv_logic_supply,
	input wire logic       uv_bottom_drive_supply,
	input wire logic       uv_reference,
	input wire logic       thermal_shutdown,
	input wire logic       out_enable,
	input wire logic       brake,
	input wire logic [2:0] sensor,
	input wire logic [2:0] top_drive_n,
	input wire logic [2:0] bottom_drive,
	input wire logic       fault_n
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// Every switch released and fault asserted
	sequence s_off; !fault_n && top_drive_n == 3'h7 && bottom_drive == 3'h0; endsequence
	// Overcurrent, then a quiet stretch with no new cycle start
	sequence s_ocur; (cur_sense && !brake) ##1 (!cur_sense && !osc_start)[*3]; endsequence
	// A clean cycle start with neither comparator firing
	sequence s_go; ($rose(osc_start) && !pwm_cmp && !cur_sense) ##1 (!pwm_cmp && !cur_sense)[*2]; endsequence
	property p_uv; (uv_logic_supply || uv_bottom_drive_supply || uv_reference) |-> ##2 s_off; endproperty
	property p_therm; thermal_shutdown && !brake |-> ##2 s_off; endproperty
	property p_enable; !out_enable && !brake |-> ##2 s_off; endproperty
	property p_cur; cur_sense && !brake |-> ##2 (!fault_n && bottom_drive == 3'h0); endproperty
	property p_pwm; pwm_cmp && !brake |-> ##3 bottom_drive == 3'h0; endproperty
	property p_hold; s_ocur |-> bottom_drive == 3'h0; endproperty
	property p_start; s_go |-> ##1 (bottom_drive != 3'h0 || !fault_n); endproperty
	property p_single; fault_n && !$past(brake, 2) |-> $onehot0(bottom_drive) && $onehot0(~top_drive_n); endproperty
	property p_top; pwm_cmp ##1 (pwm_cmp && $stable(sensor))[*3] |-> $stable(top_drive_n); endproperty
	property p_apb; psel && !penable |=> pready ##1 !pready; endproperty
	a_uv: assert property (p_uv) else $error("undervoltage left a drive on");
	a_therm: assert property (p_therm) else $error("overheat left a drive on");
	a_enable: assert property (p_enable) else $error("disable left a drive on");
	a_cur: assert property (p_cur) else $error("overcurrent not cut");
	a_pwm: assert property (p_pwm) else $error("pwm cut missing");
	a_hold: assert property (p_hold) else $error("switch back on before cycle start");
	a_start: assert property (p_start) else $error("cycle start did not set latches");
	a_single: assert property (p_single) else $error("more than one switch per side");
	a_top: assert property (p_top) else $error("pwm moved a top drive");
	a_apb: assert property (p_apb) else $error("bus answer not one cycle");
endmodule : mpwm_checker

bind mpwm_top mpwm_checker u_chk (.mclk(mclk), .reset_n(reset_n), .psel(psel),
	.penable(penable), .pready(pready), .osc_start(osc_start), .pwm_cmp(pwm_cmp),
	.cur_sense(cur_sense), .uv_logic_supply(uv_logic_supply),
	.uv_bottom_drive_supply(uv_bottom_drive_supply), .uv_reference(uv_reference),
	.thermal_shutdown(thermal_shutdown), .out_enable(out_enable), .brake(brake),
	.sensor(sensor), .top_drive_n(top_drive_n), .bottom_drive(bottom_drive), .fault_n(fault_n));

// ==== verification/mpwm_bridge_model.sv ====
`timescale 1ns/1ps
// Bridge and stator: current ramps while a top and a bottom switch conduct
module mpwm_bridge_model (
	input  wire logic       mclk,
	input  wire logic [2:0] top_drive_n,
	input  wire logic [2:0] bottom_drive,
	input  wire logic [7:0] trip,
	output logic            cur_sense
);
	logic [7:0] amps = 8'h00;
	// Current collapses as soon as the path opens; trip 0 means a light load
	always_ff @(posedge mclk) begin
		if (bottom_drive != 3'h0 && top_drive_n != 3'h7) begin
			amps <= amps + 8'h01;
		end else begin
			amps <= 8'h00;
		end
	end
	assign cur_sense = (trip != 8'h00) && (amps >= trip);
endmodule : mpwm_bridge_model

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
// Drivers queue expectations; separate monitors retire them as results appear
module testbench;
	logic        mclk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        osc_start = 1'b0, pwm_cmp = 1'b0, thermal_shutdown = 1'b0, brake = 1'b0;
	logic        out_enable = 1'b1, sel_60deg = 1'b1, fwd_rev = 1'b1;
	logic [7:0]  paddr = 8'h00, trip = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [2:0]  uv = 3'h0, sensor = 3'h4, top_drive_n, bottom_drive;
	logic        pready, pslverr, cur_sense, fault_n;
	logic [32:0] qr[$];
	logic [6:0]  qm[$];
	int          errors = 0, n_checks = 0;
	event        look;
	localparam logic [2:0] code60 [6] = '{3'h4, 3'h6, 3'h7, 3'h3, 3'h1, 3'h0};
	localparam logic [2:0] code120[6] = '{3'h4, 3'h6, 3'h2, 3'h3, 3'h1, 3'h5};
	localparam int         hi_ph  [6] = '{0, 1, 1, 2, 2, 0};
	localparam int         lo_ph  [6] = '{2, 2, 0, 0, 1, 1};
	always #4 mclk = ~mclk;
	mpwm_top uut (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .osc_start(osc_start), .pwm_cmp(pwm_cmp), .cur_sense(cur_sense),
		.uv_logic_supply(uv[0]), .uv_bottom_drive_supply(uv[1]), .uv_reference(uv[2]),
		.thermal_shutdown(thermal_shutdown), .out_enable(out_enable), .brake(brake),
		.sel_60deg(sel_60deg), .fwd_rev(fwd_rev), .sensor(sensor),
		.top_drive_n(top_drive_n), .bottom_drive(bottom_drive), .fault_n(fault_n));
	mpwm_bridge_model u_bridge (.mclk(mclk), .top_drive_n(top_drive_n),
		.bottom_drive(bottom_drive), .trip(trip), .cur_sense(cur_sense));
	task automatic compare(input string what, input logic [32:0] e, input logic [32:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask : compare
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : complete_run
	// Each completed transfer retires the oldest bus note; write data is not returned
	always @(posedge mclk) begin
		if (psel && penable && pready) begin
			compare("apb", qr.pop_front(), {pslverr, pwrite ? 32'h0 : prdata});
		end
	end
	// Each look event retires the oldest drive note
	always @(look) begin
		compare("drives", {26'h0, qm.pop_front()}, {26'h0, top_drive_n, bottom_drive, fault_n});
	end
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask : tick
	// Let the input register and output register stages settle, then look mid-cycle
	task automatic expect_drv(input logic [6:0] e);
		tick(4);
		@(negedge mclk);
		qm.push_back(e);
		-> look;
	endtask : expect_drv
	task automatic cycle_start;
		tick(1);
		osc_start <= 1'b1;
		tick(1);
		osc_start <= 1'b0;
	endtask : cycle_start
	// Request held until pready is seen; a missing answer ends the run
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] e);
		int k;
		qr.push_back(e);
		tick(1);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		tick(1);
		penable <= 1'b1;
		k = 0;
		do begin
			tick(1);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k == 20) begin
			errors++;
			complete_run();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	initial begin
		int   t;
		int   b;
		logic sel;
		logic fwd;
		logic [32:0] st_exp;
		void'($urandom(40033));
		tick(5);
		reset_n <= 1'b1;
		tick(3);
		// Registers: reset value, soft disable, refused write and unmapped read
		apb(1'b0, mpwm_pkg::ctrl_addr, 32'h0, {1'b0, 30'h0, mpwm_pkg::ctrl_reset});
		apb(1'b1, mpwm_pkg::ctrl_addr, 32'h0, 33'h0);
		expect_drv(7'h70);
		apb(1'b0, mpwm_pkg::ctrl_addr, 32'h0, 33'h0);
		apb(1'b1, mpwm_pkg::ctrl_addr, 32'h1, 33'h0);
		apb(1'b1, mpwm_pkg::status_addr, $urandom, {1'b1, 32'h0});
		apb(1'b0, 8'h0c, 32'h0, {1'b1, 32'h0});
		$display("registers done");
		// Six-step walk with random phasing and direction; pwm cut in every step
		for (int s = 0; s < 6; s++) begin
			sel = 1'($urandom);
			fwd = 1'($urandom);
			t = fwd ? hi_ph[s] : lo_ph[s];
			b = fwd ? lo_ph[s] : hi_ph[s];
			tick(1);
			sel_60deg <= sel;
			fwd_rev <= fwd;
			sensor <= sel ? code60[s] : code120[s];
			cycle_start();
			expect_drv({~(3'h1 << t), 3'h1 << b, 1'b1});
			tick(1);
			pwm_cmp <= 1'b1;
			expect_drv({~(3'h1 << t), 3'h0, 1'b1});
			tick(1);
			pwm_cmp <= 1'b0;
			expect_drv({~(3'h1 << t), 3'h0, 1'b1});
		end
		$display("commutation done");
		// Each undervoltage flag, overheat, enable low and an invalid code alone, then brake alone, with enable low and with undervoltage
		for (int i = 0; i < 9; i++) begin
			tick(1);
			sel_60deg <= 1'b1;
			fwd_rev <= 1'b1;
			uv <= (i < 3) ? 3'(1 << i) : (i == 8) ? 3'h4 : 3'h0;
			thermal_shutdown <= (i == 3);
			out_enable <= (i != 4) && (i != 7);
			sensor <= (i == 5) ? 3'h2 : code60[0];
			brake <= (i > 5);
			expect_drv((i == 6) ? 7'h7f : (i == 7) ? 7'h7e : 7'h70);
		end
		tick(1);
		uv <= 3'h0;
		out_enable <= 1'b1;
		brake <= 1'b0;
		// Soft brake bit on an invalid code: tops off, bottoms on, fault low
		sensor <= 3'h2;
		apb(1'b1, mpwm_pkg::ctrl_addr, 32'h3, 33'h0);
		expect_drv(7'h7e);
		apb(1'b1, mpwm_pkg::ctrl_addr, 32'h1, 33'h0);
		sensor <= code60[0];
		$display("protection done");
		// Bridge current trips the limit twice, once per oscillator cycle
		trip <= 8'h03;
		repeat (2) begin
			cycle_start();
			tick(8);
			expect_drv(7'h61);
		end
		apb(1'b0, mpwm_pkg::count_addr, 32'h0, 33'h2);
		// Upper latch still set, lower latch held clear, valid step zero
		st_exp = 33'((1 << mpwm_pkg::st_upper_bit) | (1 << mpwm_pkg::st_valid_bit));
		apb(1'b0, mpwm_pkg::status_addr, 32'h0, st_exp);
		$display("current limit done");
		complete_run();
	end
endmodule : testbench
